/* File: hw/lin_mode_host.sv */
// Host controller that drives the transceiver mode, transmit and reads wake pins
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Host holds transmit high for release time after any normal entry.
// - Flash entry: mode-select low interval one, then transmit fall and rise.
// - Same sequence in flash returns to slope, then release hold again.
// - Host drives transmit high to read the wake source in stand-by.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
`default_nettype none
module lin_mode_host
    import lin_mode_host_pkg::*;
(
    input wire logic ref_clk, // System clock, 25 MHz
    input wire logic sys_rst, // Synchronous reset, high
    input wire logic reqNormal, // Ask for normal slope operation (level)
    input wire logic reqSleep, // Ask for sleep (pulse)
    input wire logic reqFlashToggle, // Toggle flash sub-mode (pulse)
    input wire logic txData, // Frame data from UART, low is dominant
    output var logic txReady, // Transmit path released to txData
    output var logic inFlash, // Device is in flash sub-mode
    output var logic inNormal, // Device is in a normal sub-mode
    output var logic [1:0] wakeSource, // Last wake source seen in stand-by
    output var logic rxData, // Filtered receive level to UART
    output var logic modeSelectPin, // Mode-select pin drive
    output var logic txPinOut, // Transmit pin output value
    output var logic txPinOeN, // Transmit pin enable, low drives
    input wire logic txPinIn, // Transmit pin read-back
    input wire logic rxPin, // Receive pin from device
    input wire logic inhibitPin // Regulator-inhibit level seen
);
    host_state_t state_ff, nxt_state;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic modeSel_ff, nxt_modeSel;
    logic txOut_ff, nxt_txOut;
    logic [1:0] src_ff, nxt_src;
    logic rxSync, txSync, inhSync;

    //////////////////////////////////////////////////////////////////////////
    // Pin inputs pass three flops and an agreement register each
    pin_sync3 uRx (.ref_clk(ref_clk), .sys_rst(sys_rst), .pinIn(rxPin), .resetLevel(1'b1), .levelOut(rxSync));
    pin_sync3 uTx (.ref_clk(ref_clk), .sys_rst(sys_rst), .pinIn(txPinIn), .resetLevel(1'b1), .levelOut(txSync));
    pin_sync3 uInh (.ref_clk(ref_clk), .sys_rst(sys_rst), .pinIn(inhibitPin), .resetLevel(1'b1), .levelOut(inhSync));

    //////////////////////////////////////////////////////////////////////////
    // Decoding of a timer expiry, used in many states
    function automatic logic timeUp(input logic [CNT_W-1:0] c, input int unsigned lim);
        timeUp = (c >= CNT_W'(lim - 1));
    endfunction

    // Sequencer of the mode pins
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff + CNT_W'(1);
        nxt_modeSel = modeSel_ff;
        nxt_txOut = 1'b1;
        nxt_src = src_ff;
        case (state_ff)
            ST_SLEEP, ST_STANDBY:
            begin
                nxt_modeSel = 1'b0;
                nxt_cnt = '0;
                // Driven high so a strong pull-down shows as low
                if (state_ff == ST_STANDBY)
                    nxt_src = !rxSync ? (txSync ? SRC_BUS : SRC_LOCAL) : SRC_POWER;
                if (state_ff == ST_SLEEP && inhSync)
                    nxt_state = ST_STANDBY; // Device woke up itself
                if (reqNormal)
                begin
                    nxt_modeSel = 1'b1;
                    nxt_state = ST_ENTER;
                end
            end
            ST_ENTER:
            begin
                // Wait out the mode-change delay
                if (timeUp(cnt_ff, MODE_CHANGE_CYC))
                begin
                    nxt_state = ST_RELEASE;
                    nxt_cnt = '0;
                    nxt_src = SRC_NONE;
                end
            end
            ST_RELEASE:
            begin
                // Hold transmit high for the release time
                if (timeUp(cnt_ff, RELEASE_CYC))
                    nxt_state = ST_SLOPE;
            end
            ST_SLOPE, ST_FLASH:
            begin
                nxt_txOut = txData;
                nxt_cnt = '0;
                // Transmit goes recessive together with mode-select so no dominant bit is cut mid-change
                if (reqSleep || !reqNormal)
                begin
                    nxt_modeSel = 1'b0;
                    nxt_txOut = 1'b1;
                    nxt_state = ST_GO_SLEEP;
                end
                else if (reqFlashToggle)
                begin
                    nxt_modeSel = 1'b0;
                    nxt_txOut = 1'b1;
                    nxt_state = ST_FL_EN_LOW;
                end
            end
            ST_FL_EN_LOW:
            begin
                if (timeUp(cnt_ff, FLASH_ONE_CYC))
                begin
                    nxt_cnt = '0;
                    nxt_modeSel = 1'b1;
                    nxt_state = ST_FL_TX_LOW;
                end
            end
            ST_FL_TX_LOW:
            begin
                nxt_txOut = !timeUp(cnt_ff, FLASH_TWO_CYC); // Falling edge after interval two
                if (!nxt_txOut)
                begin
                    nxt_cnt = '0;
                    nxt_state = ST_FL_TX_HIGH;
                end
            end
            ST_FL_TX_HIGH:
            begin
                nxt_txOut = timeUp(cnt_ff, FLASH_THREE_CYC); // Rising edge after interval three
                if (nxt_txOut)
                begin
                    nxt_cnt = '0;
                    nxt_state = ST_FL_REJOIN;
                end
            end
            ST_FL_REJOIN:
            begin
                // Interval four, then release hold whether flash was entered or left
                if (timeUp(cnt_ff, FLASH_FOUR_CYC + RELEASE_CYC))
                    nxt_state = inFlash ? ST_SLOPE : ST_FLASH;
            end
            ST_GO_SLEEP:
            begin
                // Keep mode-select low long enough to be taken
                if (timeUp(cnt_ff, SLEEP_HOLD_CYC))
                    nxt_state = ST_SLEEP;
            end
            default:
            begin
                nxt_state = ST_SLEEP;
            end
        endcase
    end

    // Flash flag flips on sequence completion; cleared on the way to sleep
    logic flash_ff, nxt_flash;
    always_comb
    begin
        nxt_flash = flash_ff;
        if (state_ff == ST_FL_REJOIN && nxt_state != ST_FL_REJOIN)
            nxt_flash = !flash_ff;
        if (nxt_state == ST_SLEEP || nxt_state == ST_GO_SLEEP)
            nxt_flash = 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state_ff <= ST_SLEEP;
            cnt_ff <= '0;
            modeSel_ff <= 1'b0;
            txOut_ff <= 1'b1;
            src_ff <= SRC_NONE;
            flash_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            modeSel_ff <= nxt_modeSel;
            txOut_ff <= nxt_txOut;
            src_ff <= nxt_src;
            flash_ff <= nxt_flash;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Outputs; transmit pin always driven by the host
    assign modeSelectPin = modeSel_ff;
    assign txPinOut = txOut_ff;
    assign txPinOeN = 1'b0;
    assign inFlash = flash_ff;
    assign inNormal = (state_ff == ST_SLOPE) || (state_ff == ST_FLASH);
    assign txReady = inNormal;
    assign wakeSource = src_ff;
    assign rxData = rxSync;
endmodule
`default_nettype wire

/* File: hw/lin_mode_host_pkg.sv */
// Constants and types for the host-side controller of the bus transceiver mode pins
package lin_mode_host_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    // Durations in microseconds; plain defaults, the device gives no figures
    localparam int unsigned MODE_CHANGE_US = 10;
    localparam int unsigned RELEASE_US = 10;
    localparam int unsigned FLASH_ONE_US = 50;
    localparam int unsigned FLASH_TWO_US = 10;
    localparam int unsigned FLASH_THREE_US = 10;
    localparam int unsigned FLASH_FOUR_US = 10;
    localparam int unsigned SLEEP_HOLD_US = 100;
    // Least times round up to whole cycles
    localparam int unsigned MODE_CHANGE_CYC = (MODE_CHANGE_US * (CLK_HZ / 1000) + 999) / 1000;
    localparam int unsigned RELEASE_CYC = (RELEASE_US * (CLK_HZ / 1000) + 999) / 1000;
    localparam int unsigned FLASH_ONE_CYC = (FLASH_ONE_US * (CLK_HZ / 1000) + 999) / 1000;
    localparam int unsigned FLASH_TWO_CYC = (FLASH_TWO_US * (CLK_HZ / 1000) + 999) / 1000;
    localparam int unsigned FLASH_THREE_CYC = (FLASH_THREE_US * (CLK_HZ / 1000) + 999) / 1000;
    localparam int unsigned FLASH_FOUR_CYC = (FLASH_FOUR_US * (CLK_HZ / 1000) + 999) / 1000;
    localparam int unsigned SLEEP_HOLD_CYC = (SLEEP_HOLD_US * (CLK_HZ / 1000) + 999) / 1000;
    localparam int unsigned CNT_W = 16;
    // Wake source as read back in stand-by
    typedef enum logic [1:0] {SRC_NONE, SRC_POWER, SRC_BUS, SRC_LOCAL} wake_src_t;
    typedef enum {ST_SLEEP, ST_STANDBY, ST_ENTER, ST_RELEASE, ST_SLOPE, ST_FL_EN_LOW, ST_FL_TX_LOW,
        ST_FL_TX_HIGH, ST_FL_REJOIN, ST_FLASH, ST_GO_SLEEP} host_state_t;
endpackage

/* File: hw/pin_sync3.sv */
// Three-stage synchroniser with agreement check for one external pin
`timescale 1ns/100ps
`default_nettype none
module pin_sync3
    import lin_mode_host_pkg::*;
(
    input wire logic ref_clk, // System clock
    input wire logic sys_rst, // Synchronous reset, high
    input wire logic pinIn, // Raw pin level
    input wire logic resetLevel, // Level assumed during reset
    output var logic levelOut // Filtered level
);
    logic s1_ff, s2_ff, s3_ff, lvl_ff;
    logic nxt_lvl;
    // Change accepted once stages two and three agree
    always_comb
    begin
        nxt_lvl = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
    end
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            s1_ff <= resetLevel;
            s2_ff <= resetLevel;
            s3_ff <= resetLevel;
            lvl_ff <= resetLevel;
        end
        else
        begin
            s1_ff <= pinIn;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            lvl_ff <= nxt_lvl;
        end
    end
    assign levelOut = lvl_ff;
endmodule
`default_nettype wire

/* File: verification/lin_dev_model.sv */
// Behavioural transceiver: modes, wake source pins, bus loop-back
`timescale 1ns/100ps
`default_nettype none
module lin_dev_model
    import lin_mode_host_pkg::*;
(
    input wire logic ref_clk, // Times durations only
    input wire logic sys_rst, // Power-up event
    input wire logic modeSel, // Mode-select pin
    input wire logic txOut, // Host transmit drive
    input wire logic txOeN, // Low while host drives
    input wire logic busWake, // Bus wake pulse
    input wire logic localWake, // Local wake pulse
    output logic txIn, // Transmit pin level
    output logic rxOut, // Receive pin level
    output logic inhOut // Inhibit level, floating reads low
);
    logic [1:0] mode_ff; // 0 sleep, 1 stand-by, 2 normal
    wake_src_t src_ff;
    logic msPrev_ff;
    logic [15:0] lowCnt_ff;
    // A short low on mode-select is a flash sequence, a long one means sleep
    always_ff @(posedge ref_clk)
    begin
        msPrev_ff <= modeSel;
        lowCnt_ff <= (modeSel || sys_rst) ? 16'h0 : lowCnt_ff + 16'h1;
        if (sys_rst)
        begin
            mode_ff <= 2'h1;
            src_ff <= SRC_POWER;
        end
        else if (modeSel && !msPrev_ff && mode_ff != 2'h2)
            mode_ff <= 2'h2;
        else if (mode_ff == 2'h2 && lowCnt_ff > 16'(FLASH_ONE_CYC + FLASH_TWO_CYC))
            mode_ff <= 2'h0;
        else if (mode_ff == 2'h0 && (busWake || localWake))
        begin
            mode_ff <= 2'h1;
            src_ff <= busWake ? SRC_BUS : SRC_LOCAL;
        end
    end
    // Strong pull-down of a local wake beats the host's high drive
    assign inhOut = mode_ff != 2'h0;
    assign txIn = (mode_ff == 2'h1 && src_ff == SRC_LOCAL) ? 1'b0 : !txOeN && txOut;
    // Loop-back in both normal sub-modes; slew control has no effect at logic level
    assign rxOut = mode_ff == 2'h2 ? (txOeN | txOut) : (mode_ff == 2'h0 || src_ff == SRC_POWER);
endmodule
`default_nettype wire

/* File: verification/lin_mode_host_properties.sv */
// Concurrent checks on the host mode controller ports
`timescale 1ns/100ps
`default_nettype none
module lin_mode_host_properties
    import lin_mode_host_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic sys_rst, // Reset
    input wire logic reqNormal, // Normal request
    input wire logic reqSleep, // Sleep pulse
    input wire logic reqFlashToggle, // Flash pulse
    input wire logic txData, // Frame data
    input wire logic txReady, // Released
    input wire logic inNormal, // Normal state
    input wire logic [1:0] wakeSource, // Wake source
    input wire logic modeSelectPin, // Mode pin
    input wire logic txPinOut, // Tx drive
    input wire logic txPinOeN // Tx enable
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic [15:0] hiCnt_ff;
    logic [15:0] nxt_hiCnt;
    // Cycles the transmit pin has stood high, saturating
    always_comb nxt_hiCnt = !txPinOut ? 16'h0 : hiCnt_ff + {15'h0, hiCnt_ff != 16'hffff};
    always_ff @(posedge ref_clk) hiCnt_ff <= sys_rst ? 16'h0 : nxt_hiCnt;
    localparam int unsigned ENTRY_MAX = 1200;
    logic [15:0] upCnt_ff;
    logic [15:0] nxt_upCnt;
    // Cycles mode-select has stood high with the path not yet released; a hang shows as a runaway count
    always_comb nxt_upCnt = (!modeSelectPin || txReady) ? 16'h0 : upCnt_ff + {15'h0, upCnt_ff != 16'hffff};
    always_ff @(posedge ref_clk) upCnt_ff <= sys_rst ? 16'h0 : nxt_upCnt;
    sequence s_slope_entry;
        (!txReady)[*8];
    endsequence
    a_idle_high: assert property (!modeSelectPin |-> txPinOut && !txPinOeN) else $error("tx low while mode pin low");
    a_normal_entry: assert property ($rose(reqNormal) && !modeSelectPin |=> modeSelectPin) else $error("no mode rise");
    a_slope_delay: assert property ($rose(modeSelectPin) && !inNormal |-> s_slope_entry) else $error("bad entry");
    a_entry_bound: assert property (modeSelectPin && !txReady |-> upCnt_ff < 16'(ENTRY_MAX)) else $error("slow entry");
    a_release_hold: assert property ($rose(txReady) |-> hiCnt_ff >= 16'(RELEASE_CYC - 1)) else $error("short release");
    a_flash_low: assert property (reqFlashToggle && txReady |=> (!modeSelectPin)[*8]) else $error("flash low");
    a_sleep_drop: assert property (($fell(reqNormal) || reqSleep) && txReady |-> ##[1:3] !modeSelectPin) else $error("no sleep");
    a_wake_clear: assert property ($rose(inNormal) |-> wakeSource == 2'h0) else $error("wake not cleared");
    a_tx_follows: assert property (txReady && $past(txReady) |-> txPinOut == $past(txData)) else $error("tx path");
endmodule
bind lin_mode_host lin_mode_host_properties chk (.ref_clk, .sys_rst, .reqNormal, .reqSleep, .reqFlashToggle, .txData,
    .txReady, .inNormal, .wakeSource, .modeSelectPin, .txPinOut, .txPinOeN);
`default_nettype wire

/* File: verification/lin_transceiver_mode_control_tb.sv */
// Self-checking bench for the host mode controller with a transceiver model
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; $display("[ERR] %0t %0h %0h", $time, a, e); end end
module lin_transceiver_mode_control_tb
    import lin_mode_host_pkg::*;
;
    logic ref_clk = 1'b0, sys_rst = 1'b1, reqNormal = 1'b0, reqSleep = 1'b0, reqFlashToggle = 1'b0, txData = 1'b1;
    logic busWake = 1'b0, localWake = 1'b0;
    logic txReady, inFlash, inNormal, rxData, modeSelectPin, txPinOut, txPinOeN, txPinIn, rxPin, inhibitPin;
    logic [1:0] wakeSource;
    int fails = 0;
    int checked = 0;
    always #20 ref_clk = ~ref_clk;
    lin_mode_host dut (.ref_clk, .sys_rst, .reqNormal, .reqSleep, .reqFlashToggle, .txData, .txReady, .inFlash,
        .inNormal, .wakeSource, .rxData, .modeSelectPin, .txPinOut, .txPinOeN, .txPinIn, .rxPin, .inhibitPin);
    lin_dev_model dev (.ref_clk, .sys_rst, .modeSel(modeSelectPin), .txOut(txPinOut), .txOeN(txPinOeN), .busWake,
        .localWake, .txIn(txPinIn), .rxOut(rxPin), .inhOut(inhibitPin));
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic go_normal();
        reqNormal = 1'b1;
        for (int i = 0; i < 1200 && txReady !== 1'b1; i++) cyc(1);
        `CHK(txReady, 1'b1)
        `CHK(inNormal, 1'b1)
        `CHK(inFlash, 1'b0)
        `CHK(wakeSource, 2'h0)
    endtask
    task automatic t_traffic();
        go_normal();
        txData = 1'b0;
        cyc(8);
        `CHK({txPinOut, rxData}, 2'h0)
        txData = 1'b1;
        cyc(8);
        `CHK(rxData, 1'b1)
    endtask
    // Enter flash, then leave it by the same sequence
    task automatic t_flash();
        for (int k = 0; k < 2; k++)
        begin
            reqFlashToggle = 1'b1;
            cyc(1);
            reqFlashToggle = 1'b0;
            for (int i = 0; i < 3000 && inFlash === 1'(k); i++) cyc(1);
            for (int i = 0; i < 1200 && txReady !== 1'b1; i++) cyc(1);
            `CHK({inFlash, txReady, inNormal}, {!k[0], 2'h3})
        end
    endtask
    // Sleep, refused flash request, then a wake of either kind
    task automatic t_wake(input bit bus, input wake_src_t exp);
        go_normal();
        reqNormal = 1'b0;
        reqSleep = !bus;
        cyc(1);
        reqSleep = 1'b0;
        cyc(3000);
        `CHK({inNormal, modeSelectPin}, 2'h0)
        reqFlashToggle = 1'b1;
        cyc(1);
        reqFlashToggle = 1'b0;
        cyc(1300);
        `CHK({inFlash, modeSelectPin}, 2'h0)
        busWake = bus;
        localWake = !bus;
        cyc(1);
        {busWake, localWake} = 2'h0;
        cyc(150);
        `CHK(wakeSource, exp)
    endtask
    task automatic wrap_up();
        if (fails == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Main sequence: power-up report first, then traffic, flash, both wakes
    initial
    begin
        cyc(20);
        sys_rst = 1'b0;
        cyc(150);
        `CHK(wakeSource, SRC_POWER)
        t_traffic();
        t_flash();
        t_wake(1'b1, SRC_BUS);
        t_wake(1'b0, SRC_LOCAL);
        wrap_up();
    end
    // Watchdog, well past the roughly 15000 cycles the tests need
    initial
    begin
        cyc(60000);
        fails++;
        wrap_up();
    end
endmodule
`default_nettype wire
